/* File: core/smrc_top.v */
// Supply monitor: power-on reset sequencing and two low-voltage channels.
// How it works
// - Hold power-on reset until supply above release.
// - Supply drop reasserts power-on reset.
// - Power-on reset holds counter, core, peripherals.
// - Counter restarts from zero on release.
// - Core released only at terminal count.
// - Counter advances on oscillator ticks only.
// - Two channels, separate comparator and level.
// - Per-channel choice: reset or interrupt.
// - Reset mode: reset while supply below level.
// - Interrupt mode: request on level crossing.
// - Repeated crossings each raise a request.
// - Flags-levels register 8 bits, resets 0x20.
// - Bit layout: flag, status, level per channel.
// - Latched flag sets on low, stays set.
// - Writing 0 clears flag; 1 ignored.
// - Status flag read-only live comparator while enabled, 0 when disabled.
// - Channel 2 level accepts only code 01.
// - Channel 1 level codes 00 and 11 only.
// - Mode bit: 0 interrupt, 1 reset.
// - Enable bit 1 on, reset to 0.
// - Hardware set beats software clear.
// - Detection reset lasts while supply low.
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`include "smrc_consts.vh"
module smrc_top (
    // Clock and reset
    input wire clk_in,
    input wire rst_in,
    // Analog comparators and oscillator, all asynchronous
    input wire supply_ok_in,
    input wire ch1_below_in,
    input wire ch2_below_in,
    input wire osc_in,
    // Register port
    input wire [`SMRC_ADDR_W-1:0] addr_in,
    input wire [7:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    output reg [7:0] rdata_out,
    // Reset and event outputs
    output reg por_out,
    output reg sys_rst_out,
    output reg detect_rst_out,
    output reg low_voltage_irq_out,
    // Selected thresholds for the analog ladder
    output reg [1:0] ch1_level_out,
    output reg [1:0] ch2_level_out
);
    wire supply_ok_s;
    wire osc_s;
    wire [1:0] below_s;
    wire warm_done;
    reg osc_d;
    reg [1:0] below_d;
    reg [1:0] ch_latched;
    reg [1:0] ch1_level_select;
    reg [1:0] ch2_level_select;
    reg [1:0] channel_detect_enable;
    reg [1:0] channel_action_select;
    reg [1:0] en_d;
    wire [1:0] ch_low;
    wire [1:0] ch_irq_hit;
    wire [1:0] ch_rst_hit;
    reg [7:0] flags_levels_rd;
    reg [7:0] next_rdata;
    wire osc_tick;
    wire wr_flags;
    wire wr_mode;

    smrc_sync2 u_sync_supply (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .d_in(supply_ok_in),
        .q_out(supply_ok_s)
    );

    smrc_sync2 u_sync_osc (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .d_in(osc_in),
        .q_out(osc_s)
    );

    smrc_sync2 u_sync_ch1 (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .d_in(ch1_below_in),
        .q_out(below_s[0])
    );

    smrc_sync2 u_sync_ch2 (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .d_in(ch2_below_in),
        .q_out(below_s[1])
    );

    // One enable pulse per rising oscillator edge.
    assign osc_tick = osc_s & ~osc_d;

    smrc_warmup u_warmup (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .hold_in(por_out),
        .osc_tick_in(osc_tick),
        .done_out(warm_done)
    );

    assign wr_flags = wr_in && (addr_in == `SMRC_ADDR_FLAGS_LEVELS);
    assign wr_mode = wr_in && (addr_in == `SMRC_ADDR_ENABLE_MODE);

    // Power-on reset and system reset sequencing.
    always @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            por_out <= 1'b1;
            sys_rst_out <= 1'b1;
            osc_d <= 1'b0;
        end
        else
        begin
            osc_d <= osc_s;
            por_out <= ~supply_ok_s;
            if (por_out)
            begin
                sys_rst_out <= 1'b1;
            end
            else if (warm_done)
            begin
                sys_rst_out <= 1'b0;
            end
        end
    end

    // Per-channel detection: live status, events and reset request.
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1)
        begin : g_ch
            assign ch_low[gi] = channel_detect_enable[gi] & below_s[gi];
            // Every comparator change while enabled in interrupt mode is an event, and so is enabling
            // a channel whose supply already sits below its level.
            assign ch_irq_hit[gi] = channel_detect_enable[gi] & ~channel_action_select[gi]
                & ((below_s[gi] ^ below_d[gi])
                | (below_s[gi] & ~(below_d[gi] & en_d[gi])));
            assign ch_rst_hit[gi] = ch_low[gi] & channel_action_select[gi];
        end
    endgenerate

    // Control registers; power-on reset reinitialises them too.
    always @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            below_d <= 2'h0;
            en_d <= 2'h0;
            ch_latched <= 2'h0;
            ch1_level_select <= `SMRC_CH1_LVL_RST;
            ch2_level_select <= `SMRC_CH2_LVL_RST;
            channel_detect_enable <= 2'h0;
            channel_action_select <= 2'h0;
            detect_rst_out <= 1'b0;
            low_voltage_irq_out <= 1'b0;
            ch1_level_out <= `SMRC_CH1_LVL_RST;
            ch2_level_out <= `SMRC_CH2_LVL_RST;
        end
        else if (por_out)
        begin
            below_d <= below_s;
            en_d <= 2'h0;
            ch_latched <= 2'h0;
            ch1_level_select <= `SMRC_CH1_LVL_RST;
            ch2_level_select <= `SMRC_CH2_LVL_RST;
            channel_detect_enable <= 2'h0;
            channel_action_select <= 2'h0;
            detect_rst_out <= 1'b0;
            low_voltage_irq_out <= 1'b0;
            ch1_level_out <= `SMRC_CH1_LVL_RST;
            ch2_level_out <= `SMRC_CH2_LVL_RST;
        end
        else
        begin
            below_d <= below_s;
            en_d <= channel_detect_enable;
            if (wr_flags)
            begin
                // Flag bits only clear on 0; detection below overrides.
                if (!wdata_in[`SMRC_CH1_FLAG_BIT])
                begin
                    ch_latched[0] <= 1'b0;
                end
                if (!wdata_in[`SMRC_CH2_FLAG_BIT])
                begin
                    ch_latched[1] <= 1'b0;
                end
                if ((wdata_in[`SMRC_CH1_LVL_HI:`SMRC_CH1_LVL_LO] == `SMRC_CH1_LVL_HIGH_BAND)
                    || (wdata_in[`SMRC_CH1_LVL_HI:`SMRC_CH1_LVL_LO]
                    == `SMRC_CH1_LVL_LOW_BAND))
                begin
                    ch1_level_select <= wdata_in[`SMRC_CH1_LVL_HI:`SMRC_CH1_LVL_LO];
                end
                if (wdata_in[`SMRC_CH2_LVL_HI:`SMRC_CH2_LVL_LO] == `SMRC_CH2_LVL_OK)
                begin
                    ch2_level_select <= wdata_in[`SMRC_CH2_LVL_HI:`SMRC_CH2_LVL_LO];
                end
            end
            if (ch_low[0])
            begin
                ch_latched[0] <= 1'b1;
            end
            if (ch_low[1])
            begin
                ch_latched[1] <= 1'b1;
            end
            if (wr_mode)
            begin
                channel_detect_enable[0] <= wdata_in[`SMRC_EN_CH1_BIT];
                channel_action_select[0] <= wdata_in[`SMRC_MOD_CH1_BIT];
                channel_detect_enable[1] <= wdata_in[`SMRC_EN_CH2_BIT];
                channel_action_select[1] <= wdata_in[`SMRC_MOD_CH2_BIT];
            end
            detect_rst_out <= |ch_rst_hit;
            low_voltage_irq_out <= |ch_irq_hit;
            ch1_level_out <= ch1_level_select;
            ch2_level_out <= ch2_level_select;
        end
    end

    always @*
    begin
        flags_levels_rd = 8'h00;
        flags_levels_rd[`SMRC_CH2_FLAG_BIT] = ch_latched[1];
        flags_levels_rd[`SMRC_CH2_STAT_BIT] = ch_low[1];
        flags_levels_rd[`SMRC_CH2_LVL_HI:`SMRC_CH2_LVL_LO] = ch2_level_select;
        flags_levels_rd[`SMRC_CH1_FLAG_BIT] = ch_latched[0];
        flags_levels_rd[`SMRC_CH1_STAT_BIT] = ch_low[0];
        flags_levels_rd[`SMRC_CH1_LVL_HI:`SMRC_CH1_LVL_LO] = ch1_level_select;
        next_rdata = 8'h00;
        if (rd_in && addr_in == `SMRC_ADDR_FLAGS_LEVELS)
        begin
            next_rdata = flags_levels_rd;
        end
        else if (rd_in && addr_in == `SMRC_ADDR_ENABLE_MODE)
        begin
            next_rdata[`SMRC_EN_CH1_BIT] = channel_detect_enable[0];
            next_rdata[`SMRC_MOD_CH1_BIT] = channel_action_select[0];
            next_rdata[`SMRC_EN_CH2_BIT] = channel_detect_enable[1];
            next_rdata[`SMRC_MOD_CH2_BIT] = channel_action_select[1];
        end
    end

    always @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            rdata_out <= 8'h00;
        end
        else
        begin
            rdata_out <= next_rdata;
        end
    end
endmodule // smrc_top

/* File: core/smrc_consts.vh */
// Constants shared by the supply monitor and reset controller.
`ifndef SMRC_CONSTS_VH
`define SMRC_CONSTS_VH
`define SMRC_ADDR_W 8
`define SMRC_ADDR_FLAGS_LEVELS 8'h2b
`define SMRC_ADDR_ENABLE_MODE 8'h2c
`define SMRC_FLAGS_LEVELS_RST 8'h20
`define SMRC_ENABLE_MODE_RST 4'h0
`define SMRC_CH2_FLAG_BIT 7
`define SMRC_CH2_STAT_BIT 6
`define SMRC_CH2_LVL_HI 5
`define SMRC_CH2_LVL_LO 4
`define SMRC_CH1_FLAG_BIT 3
`define SMRC_CH1_STAT_BIT 2
`define SMRC_CH1_LVL_HI 1
`define SMRC_CH1_LVL_LO 0
`define SMRC_CH2_LVL_RST 2'h2
`define SMRC_CH1_LVL_RST 2'h0
`define SMRC_CH2_LVL_OK 2'h1
`define SMRC_CH1_LVL_HIGH_BAND 2'h0
`define SMRC_CH1_LVL_LOW_BAND 2'h3
`define SMRC_EN_CH1_BIT 0
`define SMRC_MOD_CH1_BIT 1
`define SMRC_EN_CH2_BIT 2
`define SMRC_MOD_CH2_BIT 3
`define SMRC_WARMUP_W 16
`define SMRC_WARMUP_TERM 16'h7fff
`define SMRC_WARMUP_ZERO 16'h0000
`endif

/* File: core/smrc_sync2.v */
// Two flip-flop synchroniser for asynchronous level inputs.
`timescale 1ns/1ps
module smrc_sync2 (
    // Clock and reset
    input wire clk_in,
    input wire rst_in,
    // Level in and out
    input wire d_in,
    output reg q_out
);
    reg stage1;

    always @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            stage1 <= 1'b0;
            q_out <= 1'b0;
        end
        else
        begin
            stage1 <= d_in;
            q_out <= stage1;
        end
    end
endmodule // smrc_sync2

/* File: core/smrc_warmup.v */
// Warm-up counter advanced by oscillator tick enables.
`timescale 1ns/1ps
`include "smrc_consts.vh"
module smrc_warmup (
    // Clock and reset
    input wire clk_in,
    input wire rst_in,
    // Control
    input wire hold_in,
    input wire osc_tick_in,
    // Status
    output reg done_out
);
    reg [`SMRC_WARMUP_W-1:0] count;

    always @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            count <= `SMRC_WARMUP_ZERO;
            done_out <= 1'b0;
        end
        else if (hold_in)
        begin
            count <= `SMRC_WARMUP_ZERO;
            done_out <= 1'b0;
        end
        else if (!done_out && osc_tick_in)
        begin
            count <= count + 1'b1;
            if (count == `SMRC_WARMUP_TERM - 1'b1)
            begin
                done_out <= 1'b1;
            end
        end
    end
endmodule // smrc_warmup

/* File: sim/smrc_analog_model.sv */
// Comparators and free-running oscillator on the analog side.
`timescale 1ns/1ps
module smrc_analog_model (
    // Levels set by the bench
    input wire logic sup_in,
    input wire logic c1_in,
    input wire logic c2_in,
    // Comparator and oscillator outputs
    output logic sup_ok_out,
    output logic c1_low_out,
    output logic c2_low_out,
    output logic osc_out
);
    assign #3 sup_ok_out = sup_in;
    assign #3 c1_low_out = c1_in;
    assign #3 c2_low_out = c2_in;
    // Each half period outlasts one system clock so no edge is lost.
    initial osc_out = 1'b0;
    always #26 osc_out = ~osc_out;
endmodule // smrc_analog_model

/* File: sim/smrc_top_sva.sv */
// Port-level checks for the supply monitor.
`timescale 1ns/1ps
module smrc_top_sva (
    // Design top ports
    input wire clk_in,
    input wire rst_in,
    input wire supply_ok_in,
    input wire ch1_below_in,
    input wire ch2_below_in,
    input wire osc_in,
    input wire [7:0] addr_in,
    input wire [7:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    input wire [7:0] rdata_out,
    input wire por_out,
    input wire sys_rst_out,
    input wire detect_rst_out,
    input wire low_voltage_irq_out,
    input wire [1:0] ch1_level_out,
    input wire [1:0] ch2_level_out
);
    // A synchronised oscillator edge needs at least two clock cycles.
    localparam int WARM_MIN = 65530;
    logic [17:0] low_cnt;
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    always @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            low_cnt <= 18'h00000;
        else if (por_out)
            low_cnt <= 18'h00000;
        else if (low_cnt != 18'h3ffff)
            low_cnt <= low_cnt + 18'h00001;
    end
    sequence s_wr_lvl;
        wr_in && !por_out && addr_in == 8'h2b;
    endsequence
    property p_por_release;
        !rst_in && supply_ok_in |-> ##3 !por_out;
    endproperty
    a_por_release: assert property (p_por_release) else $error("por held");
    property p_por_drop;
        !supply_ok_in |-> ##3 por_out;
    endproperty
    a_por_drop: assert property (p_por_drop) else $error("por missing");
    property p_core_hold;
        por_out |=> sys_rst_out;
    endproperty
    a_core_hold: assert property (p_core_hold) else $error("core free");
    property p_warmup;
        $fell(sys_rst_out) |-> low_cnt >= WARM_MIN;
    endproperty
    a_warmup: assert property (p_warmup) else $error("warm-up short");
    property p_detect;
        detect_rst_out |-> $past(ch1_below_in, 3) || $past(ch2_below_in, 3);
    endproperty
    a_detect: assert property (p_detect) else $error("detect without low");
    property p_ch2_keep;
        s_wr_lvl ##0 wdata_in[5:4] != 2'h1 ##1 !por_out |=> $stable(ch2_level_out);
    endproperty
    a_ch2_keep: assert property (p_ch2_keep) else $error("ch2 took bad code");
    property p_ch2_set;
        s_wr_lvl ##0 wdata_in[5:4] == 2'h1 ##1 !por_out |=> ch2_level_out == 2'h1;
    endproperty
    a_ch2_set: assert property (p_ch2_set) else $error("ch2 code lost");
    property p_ch1_set;
        s_wr_lvl ##0 (wdata_in[1:0] == 2'h0 || wdata_in[1:0] == 2'h3) ##1 !por_out
            |=> ch1_level_out == $past(wdata_in[1:0], 2);
    endproperty
    a_ch1_set: assert property (p_ch1_set) else $error("ch1 code lost");
endmodule // smrc_top_sva

/* File: sim/testbench.sv */
// Self-checking bench for the supply monitor and reset controller.
`timescale 1ns/1ps
module testbench;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic sup = 1'b1, c1 = 1'b0, c2 = 1'b0, sok, b1, b2, osc;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic wr = 1'b0, rd = 1'b0, por, srst, drst, irq;
    logic [1:0] l1, l2;
    int n_mismatch = 0, cmp_count = 0, n_irq = 0, cyc = 0, t_rel = 0;
    always #12.5 clk_in = ~clk_in;
    smrc_analog_model i_ana (.sup_in(sup), .c1_in(c1), .c2_in(c2), .sup_ok_out(sok),
        .c1_low_out(b1), .c2_low_out(b2), .osc_out(osc));
    smrc_top i_dut (.clk_in(clk_in), .rst_in(rst_in), .supply_ok_in(sok), .ch1_below_in(b1),
        .ch2_below_in(b2), .osc_in(osc), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
        .rd_in(rd), .rdata_out(rdata), .por_out(por), .sys_rst_out(srst),
        .detect_rst_out(drst), .low_voltage_irq_out(irq), .ch1_level_out(l1),
        .ch2_level_out(l2));
    task automatic test_done;
        $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_in);
        rd <= 1'b0;
        #1 chk("rdata", rdata, e);
    endtask
    // Warm-up alone takes about 68000 cycles.
    always @(posedge clk_in)
    begin
        cyc <= cyc + 1;
        if (irq === 1'b1)
            n_irq <= n_irq + 1;
        if (cyc == 90000)
        begin
            n_mismatch++;
            test_done;
        end
    end
    initial
    begin
        repeat (10) @(posedge clk_in);
        rst_in <= 1'b0;
        wait (por === 1'b0);
        t_rel = cyc;
        chk("sys_rst", {7'h00, srst}, 8'h01);
        rd_reg(8'h2b, 8'h20);
        rd_reg(8'h2c, 8'h00);
        rd_reg(8'h2d, 8'h00);
        wr_reg(8'h2b, 8'h31);
        rd_reg(8'h2b, 8'h20);
        wr_reg(8'h2b, 8'h13);
        rd_reg(8'h2b, 8'h13);
        chk("levels", {4'h0, l2, l1}, 8'h07);
        wr_reg(8'h2b, 8'h10);
        wr_reg(8'h2c, 8'h01);
        c1 <= 1'b1;
        repeat (6) @(posedge clk_in);
        rd_reg(8'h2b, 8'h1c);
        wr_reg(8'h2b, 8'h1c);
        c1 <= 1'b0;
        repeat (6) @(posedge clk_in);
        rd_reg(8'h2b, 8'h18);
        chk("irq_count", n_irq[7:0], 8'h02);
        wr_reg(8'h2b, 8'h10);
        rd_reg(8'h2b, 8'h10);
        wr_reg(8'h2c, 8'hfd);
        rd_reg(8'h2c, 8'h0d);
        c2 <= 1'b1;
        repeat (30) @(posedge clk_in);
        chk("detect_rst", {7'h00, drst}, 8'h01);
        rd_reg(8'h2b, 8'hd0);
        c2 <= 1'b0;
        repeat (6) @(posedge clk_in);
        chk("detect_rst", {7'h00, drst}, 8'h00);
        chk("irq_count", n_irq[7:0], 8'h02);
        wr_reg(8'h2c, 8'h00);
        c1 <= 1'b1;
        repeat (6) @(posedge clk_in);
        rd_reg(8'h2b, 8'h90);
        wr_reg(8'h2c, 8'h01);
        repeat (6) @(posedge clk_in);
        chk("irq_count", n_irq[7:0], 8'h03);
        c1 <= 1'b0;
        wait (srst === 1'b0);
        chk("warm_long", {7'h00, (cyc - t_rel) >= 65530}, 8'h01);
        sup <= 1'b0;
        repeat (6) @(posedge clk_in);
        chk("por_sys", {6'h00, por, srst}, 8'h03);
        sup <= 1'b1;
        wait (por === 1'b0);
        repeat (2) @(posedge clk_in);
        chk("sys_rst", {7'h00, srst}, 8'h01);
        rd_reg(8'h2b, 8'h20);
        rd_reg(8'h2c, 8'h00);
        test_done;
    end
endmodule // testbench
bind smrc_top smrc_top_sva i_sva (.clk_in(clk_in), .rst_in(rst_in),
    .supply_ok_in(supply_ok_in), .ch1_below_in(ch1_below_in), .ch2_below_in(ch2_below_in),
    .osc_in(osc_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .por_out(por_out), .sys_rst_out(sys_rst_out),
    .detect_rst_out(detect_rst_out), .low_voltage_irq_out(low_voltage_irq_out),
    .ch1_level_out(ch1_level_out), .ch2_level_out(ch2_level_out));
